// ---- jlc_pkg.sv ----
// Purpose: shared constants and types for the link control registers and their controller
// Assumes: one clock, synchronous active-high reset on both ends
// Notes:   device register addresses are byte addresses of 8-bit registers
package jlc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int JLC_AW  = 10;
  localparam int JLC_DW  = 8;
  localparam int JLC_KW  = 16;
  localparam int JLC_HAW = 4;
  localparam int JLC_HDW = 16;

  // ----------------------------------------------------------------
  // device register map
  // ----------------------------------------------------------------
  localparam logic [JLC_AW-1:0] JLC_ADDR_LINK_ENABLE = 10'h200;
  localparam logic [JLC_AW-1:0] JLC_ADDR_OUTPUT_MODE = 10'h201;
  localparam logic [JLC_AW-1:0] JLC_ADDR_FPM         = 10'h202;
  localparam logic [JLC_AW-1:0] JLC_ADDR_SW_SYNC     = 10'h203;
  // span of link configuration registers guarded against live changes, except the software sync register at 10'h203
  localparam logic [JLC_AW-1:0] JLC_ADDR_CFG_LO      = 10'h201;
  localparam logic [JLC_AW-1:0] JLC_ADDR_CFG_HI      = 10'h20f;

  localparam logic [JLC_DW-1:0] JLC_RST_LINK_ENABLE  = 8'h01;
  localparam logic [JLC_DW-1:0] JLC_RST_OUTPUT_MODE  = 8'h00;
  localparam logic [JLC_DW-1:0] JLC_RST_FPM          = 8'h1f;
  localparam logic [JLC_DW-1:0] JLC_RST_SW_SYNC      = 8'h01;

  localparam logic [JLC_DW-1:0] JLC_MASK_LINK_ENABLE = 8'h01;
  localparam logic [JLC_DW-1:0] JLC_MASK_OUTPUT_MODE = 8'h3f;
  localparam logic [JLC_DW-1:0] JLC_MASK_FPM         = 8'hff;
  localparam logic [JLC_DW-1:0] JLC_MASK_SW_SYNC     = 8'h01;

  // ----------------------------------------------------------------
  // sync source selection and link constants
  // ----------------------------------------------------------------
  localparam logic [1:0]        JLC_SYNC_SEL_SE      = 2'h0;
  localparam logic [1:0]        JLC_SYNC_SEL_TMSTP   = 2'h1;
  localparam logic [1:0]        JLC_SYNC_SEL_NONE    = 2'h2;
  localparam logic [JLC_KW-1:0] JLC_K_SCALE          = 16'h0100;
  // pin synchroniser idle levels: {sysref, tmstp sync_n, se sync_n}
  localparam logic [2:0]        JLC_PIN_IDLE         = 3'h3;

  // ----------------------------------------------------------------
  // controller registers
  // ----------------------------------------------------------------
  localparam logic [JLC_HAW-1:0] JLC_H_ADDR          = 4'h0;
  localparam logic [JLC_HAW-1:0] JLC_H_DATA          = 4'h1;
  localparam logic [JLC_HAW-1:0] JLC_H_GO            = 4'h2;
  localparam logic [JLC_HAW-1:0] JLC_H_STATUS        = 4'h3;
  localparam logic [JLC_HAW-1:0] JLC_H_RDATA         = 4'h4;
  localparam int                 JLC_GO_WRITE        = 0;
  localparam int                 JLC_GO_READ         = 1;
  localparam int                 JLC_ST_BUSY         = 0;
  localparam int                 JLC_ST_DONE         = 1;
  localparam int                 JLC_ST_REFUSED      = 2;
  localparam int                 JLC_ST_LINK_EN      = 3;
  localparam int                 JLC_ST_CAL_CLR_OK   = 4;

  typedef enum logic [1:0] {
    JLC_S_IDLE  = 2'b00,
    JLC_S_ISSUE = 2'b01,
    JLC_S_READ  = 2'b10
  } jlc_state_t;

endpackage

// ---- jlc_link_if.sv ----
// Purpose: register access path between controller and link control registers
// Assumes: controller drives every request; read data stand one cycle after the read strobe
// Notes:   strobes are single-cycle and never both high
`timescale 1ns/1ns
interface jlc_link_if
  import jlc_pkg::*;
(
  input wire logic clk
);
  logic [JLC_AW-1:0] reg_addr;
  logic [JLC_DW-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [JLC_DW-1:0] reg_rdata;

  modport device (input clk, input reg_addr, input reg_wdata, input reg_wr, input reg_rd,
                  output reg_rdata);
  modport host   (input clk, input reg_rdata,
                  output reg_addr, output reg_wdata, output reg_wr, output reg_rd);
endinterface

// ---- jlc_device.sv ----
// Purpose: link control registers of the converter and the logic they steer
// Assumes: clk is also the frame tick for the multiframe counter
// Notes:   pins and sysref pass a three-stage filter before use
`timescale 1ns/1ns

module jlc_device
  import jlc_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // register access
  jlc_link_if.device             bus,
  // system inputs
  input  wire logic              cal_enable,
  input  wire logic [1:0]        sync_sel,
  input  wire logic              mode_is_64b66b,
  input  wire logic [7:0]        mode_e,
  input  wire logic [7:0]        mode_f,
  // pins
  input  wire logic              sync_se_n,
  input  wire logic              sync_tmstp_n,
  input  wire logic              sysref,
  // link control outputs
  output logic                   link_block_reset,
  output logic                   serializer_power_down,
  output logic                   link_clock_enable,
  output logic [5:0]             output_mode_select,
  output logic [JLC_KW-1:0]      effective_k,
  output logic                   sync_request,
  output logic [JLC_KW-1:0]      multiframe_count,
  output logic                   multiframe_boundary
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic              link_enable;
  logic [5:0]        mode_field;
  logic [JLC_DW-1:0] frames_per_multiframe_less_one;
  logic              software_sync_request_n;
  logic [JLC_DW-1:0] rdata;
  logic [JLC_KW-1:0] next_k;
  logic [JLC_KW-1:0] k_scaled;
  logic              pin_request;
  logic [2:0]        pin_s1;
  logic [2:0]        pin_s2;
  logic [2:0]        pin_s3;
  logic [2:0]        pin_level;
  logic              sysref_prev;

  function automatic logic jlc_hit(input logic [JLC_AW-1:0] a, input logic [JLC_AW-1:0] t);
    jlc_hit = (a == t);
  endfunction

  // cal_enable is ordered by software; the bank does not use it, the controller screens writes on it
  logic unused_cal;
  assign unused_cal = cal_enable;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      link_enable <= JLC_RST_LINK_ENABLE[0];
    end else if (bus.reg_wr && jlc_hit(bus.reg_addr, JLC_ADDR_LINK_ENABLE)) begin
      link_enable <= bus.reg_wdata[0];
    end
  end

  // writes taken as issued; ordering against the link enable is the controller's duty
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_field <= JLC_RST_OUTPUT_MODE[5:0];
    end else if (bus.reg_wr && jlc_hit(bus.reg_addr, JLC_ADDR_OUTPUT_MODE)) begin
      mode_field <= bus.reg_wdata[5:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      frames_per_multiframe_less_one <= JLC_RST_FPM;
    end else if (bus.reg_wr && jlc_hit(bus.reg_addr, JLC_ADDR_FPM)) begin
      frames_per_multiframe_less_one <= bus.reg_wdata & JLC_MASK_FPM;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      software_sync_request_n <= JLC_RST_SW_SYNC[0];
    end else if (bus.reg_wr && jlc_hit(bus.reg_addr, JLC_ADDR_SW_SYNC)) begin
      software_sync_request_n <= bus.reg_wdata[0];
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  // reserved bits are not stored, so they read back as zero
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else if (bus.reg_rd) begin
      if (jlc_hit(bus.reg_addr, JLC_ADDR_LINK_ENABLE)) begin
        rdata <= {7'h00, link_enable};
      end else if (jlc_hit(bus.reg_addr, JLC_ADDR_OUTPUT_MODE)) begin
        rdata <= {2'h0, mode_field};
      end else if (jlc_hit(bus.reg_addr, JLC_ADDR_FPM)) begin
        rdata <= frames_per_multiframe_less_one;
      end else if (jlc_hit(bus.reg_addr, JLC_ADDR_SW_SYNC)) begin
        rdata <= {7'h00, software_sync_request_n};
      end else begin
        rdata <= 8'h00;
      end
    end else begin
      rdata <= 8'h00;
    end
  end

  assign bus.reg_rdata = rdata;

  // ----------------------------------------------------------------
  // link enable effects and output mode select
  // ----------------------------------------------------------------
  assign link_block_reset      = ~link_enable;
  assign serializer_power_down = ~link_enable;
  assign link_clock_enable     = link_enable;
  assign output_mode_select    = mode_field;

  // ----------------------------------------------------------------
  // effective frames per multiframe
  // ----------------------------------------------------------------
  always_comb begin
    k_scaled = 16'h0000;
    if (mode_f != 8'h00) begin
      k_scaled = (16'(mode_e) * JLC_K_SCALE) / 16'(mode_f);
    end
    if (mode_is_64b66b && (mode_f != 8'h00)) begin
      next_k = k_scaled;
    end else begin
      next_k = 16'(frames_per_multiframe_less_one) + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      effective_k <= 16'(JLC_RST_FPM) + 16'h0001;
    end else begin
      effective_k <= next_k;
    end
  end

  // ----------------------------------------------------------------
  // pin filters
  // ----------------------------------------------------------------
  // level changes only once stages two and three agree; stage one feeds only stage two
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      logic pin_raw;
      if (gi == 0) begin : g_se
        assign pin_raw = sync_se_n;
      end else if (gi == 1) begin : g_tm
        assign pin_raw = sync_tmstp_n;
      end else begin : g_sr
        assign pin_raw = sysref;
      end
      always_ff @(posedge clk) begin
        if (srst) begin
          pin_s1[gi]    <= JLC_PIN_IDLE[gi];
          pin_s2[gi]    <= JLC_PIN_IDLE[gi];
          pin_s3[gi]    <= JLC_PIN_IDLE[gi];
          pin_level[gi] <= JLC_PIN_IDLE[gi];
        end else begin
          pin_s1[gi] <= pin_raw;
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
          if (pin_s2[gi] == pin_s3[gi]) begin
            pin_level[gi] <= pin_s3[gi];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // sync request
  // ----------------------------------------------------------------
  // a selected pin stuck low keeps requesting until the select moves off that pin
  always_comb begin
    case (sync_sel)
      JLC_SYNC_SEL_SE:    pin_request = ~pin_level[0];
      JLC_SYNC_SEL_TMSTP: pin_request = ~pin_level[1];
      JLC_SYNC_SEL_NONE:  pin_request = 1'b0;
      default:            pin_request = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sync_request <= 1'b0;
    end else begin
      sync_request <= pin_request | ~software_sync_request_n;
    end
  end

  // ----------------------------------------------------------------
  // multiframe counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      sysref_prev <= 1'b0;
    end else begin
      sysref_prev <= pin_level[2];
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !link_enable) begin
      multiframe_count <= 16'h0000;
    end else if (pin_level[2] && !sysref_prev) begin
      multiframe_count <= 16'h0000;
    end else if (multiframe_count + 16'h0001 >= effective_k) begin
      multiframe_count <= 16'h0000;
    end else begin
      multiframe_count <= multiframe_count + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !link_enable) begin
      multiframe_boundary <= 1'b0;
    end else begin
      multiframe_boundary <= (multiframe_count + 16'h0001 >= effective_k) ||
                             (pin_level[2] && !sysref_prev);
    end
  end

endmodule

// ---- jlc_host.sv ----
// Purpose: controller that issues register accesses and keeps their ordering safe
// Assumes: software port reads return data one cycle after the read strobe
// Notes:   refused writes never reach the registers and set a sticky flag
`timescale 1ns/1ns
module jlc_host
  import jlc_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               srst,
  // register access
  jlc_link_if.host                bus,
  // software port
  input  wire logic [JLC_HAW-1:0] sw_addr,
  input  wire logic [JLC_HDW-1:0] sw_wdata,
  input  wire logic               sw_wr,
  input  wire logic               sw_rd,
  output logic      [JLC_HDW-1:0] sw_rdata,
  // system state
  input  wire logic               cal_enable,
  input  wire logic               fpm_legal,
  output logic                    cal_clear_allowed
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  jlc_state_t        state;
  logic [JLC_AW-1:0] cmd_addr;
  logic [JLC_DW-1:0] cmd_data;
  logic [JLC_DW-1:0] read_data;
  logic              done;
  logic              refused;
  logic              link_en_shadow;
  logic              is_write;
  logic              go;
  logic              go_wr;
  logic              bad;
  logic [JLC_DW-1:0] clean;

  assign go    = sw_wr && (sw_addr == JLC_H_GO) && (state == JLC_S_IDLE);
  assign go_wr = go && sw_wdata[JLC_GO_WRITE];

  // ----------------------------------------------------------------
  // write screening
  // ----------------------------------------------------------------
  always_comb begin
    bad   = 1'b0;
    clean = cmd_data;
    case (cmd_addr)
      JLC_ADDR_LINK_ENABLE: begin
        clean = cmd_data & JLC_MASK_LINK_ENABLE;
        bad   = clean[0] && !cal_enable;
      end
      JLC_ADDR_OUTPUT_MODE: begin
        clean = cmd_data & JLC_MASK_OUTPUT_MODE;
        bad   = link_en_shadow || cal_enable;
      end
      JLC_ADDR_FPM: begin
        bad   = link_en_shadow || !fpm_legal;
      end
      JLC_ADDR_SW_SYNC: begin
        clean = cmd_data & JLC_MASK_SW_SYNC;
      end
      default: begin
        bad   = link_en_shadow && (cmd_addr >= JLC_ADDR_CFG_LO) &&
                (cmd_addr <= JLC_ADDR_CFG_HI);
      end
    endcase
  end

  assign cal_clear_allowed = ~link_en_shadow;

  // ----------------------------------------------------------------
  // command registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_addr <= JLC_ADDR_LINK_ENABLE;
      cmd_data <= 8'h00;
    end else if (sw_wr && state == JLC_S_IDLE) begin
      if (sw_addr == JLC_H_ADDR) begin
        cmd_addr <= sw_wdata[JLC_AW-1:0];
      end
      if (sw_addr == JLC_H_DATA) begin
        cmd_data <= sw_wdata[JLC_DW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state         <= JLC_S_IDLE;
      is_write      <= 1'b0;
      bus.reg_wr    <= 1'b0;
      bus.reg_rd    <= 1'b0;
      bus.reg_addr  <= 10'h000;
      bus.reg_wdata <= 8'h00;
    end else begin
      bus.reg_wr <= 1'b0;
      bus.reg_rd <= 1'b0;
      case (state)
        JLC_S_IDLE: begin
          if (go && !(go_wr && bad) && (go_wr || sw_wdata[JLC_GO_READ])) begin
            state         <= JLC_S_ISSUE;
            is_write      <= go_wr;
            bus.reg_wr    <= go_wr;
            bus.reg_rd    <= !go_wr;
            bus.reg_addr  <= cmd_addr;
            bus.reg_wdata <= clean;
          end
        end
        JLC_S_ISSUE: begin
          state <= is_write ? JLC_S_IDLE : JLC_S_READ;
        end
        JLC_S_READ: begin
          state <= JLC_S_IDLE;
        end
        default: begin
          state <= JLC_S_IDLE;
        end
      endcase
    end
  end

  // shadow follows the device reset value and every accepted enable write
  always_ff @(posedge clk) begin
    if (srst) begin
      link_en_shadow <= JLC_RST_LINK_ENABLE[0];
    end else if (state == JLC_S_ISSUE && is_write && bus.reg_addr == JLC_ADDR_LINK_ENABLE) begin
      link_en_shadow <= bus.reg_wdata[0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      read_data <= 8'h00;
    end else if (state == JLC_S_READ) begin
      read_data <= bus.reg_rdata;
    end
  end

  // ----------------------------------------------------------------
  // sticky status, write one to clear, set wins
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      done <= 1'b0;
    end else if ((state == JLC_S_ISSUE && is_write) || state == JLC_S_READ ||
                 (go_wr && bad)) begin
      done <= 1'b1;
    end else if (sw_wr && sw_addr == JLC_H_STATUS && sw_wdata[JLC_ST_DONE]) begin
      done <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      refused <= 1'b0;
    end else if (go_wr && bad) begin
      refused <= 1'b1;
    end else if (sw_wr && sw_addr == JLC_H_STATUS && sw_wdata[JLC_ST_REFUSED]) begin
      refused <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // software reads
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      sw_rdata <= 16'h0000;
    end else if (sw_rd) begin
      case (sw_addr)
        JLC_H_ADDR:   sw_rdata <= 16'(cmd_addr);
        JLC_H_DATA:   sw_rdata <= 16'(cmd_data);
        JLC_H_STATUS: sw_rdata <= 16'({~link_en_shadow, link_en_shadow, refused, done,
                                       state != JLC_S_IDLE});
        JLC_H_RDATA:  sw_rdata <= 16'(read_data);
        default:      sw_rdata <= 16'h0000;
      endcase
    end else begin
      sw_rdata <= 16'h0000;
    end
  end

endmodule

// ---- jlc_link_checker.sv ----
// Purpose: bus-side checks between controller and link control registers
// Assumes: one clock, srst synchronous active high
// Notes:   shadows mirror the last write that reached each register
`timescale 1ns/1ns
module jlc_link_checker
  import jlc_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              srst,
  // register path
  input wire logic [JLC_AW-1:0] reg_addr,
  input wire logic [JLC_DW-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [JLC_DW-1:0] reg_rdata
);
  // ----------------------------------------------------------------
  // shadows
  // ----------------------------------------------------------------
  logic       en_sh;
  logic [5:0] mode_sh;
  logic [7:0] fpm_sh;
  logic       sync_sh;
  always_ff @(posedge clk) begin
    if (srst) begin
      en_sh   <= JLC_RST_LINK_ENABLE[0];
      mode_sh <= JLC_RST_OUTPUT_MODE[5:0];
      fpm_sh  <= JLC_RST_FPM;
      sync_sh <= JLC_RST_SW_SYNC[0];
    end else if (reg_wr) begin
      case (reg_addr)
        JLC_ADDR_LINK_ENABLE: en_sh <= reg_wdata[0];
        JLC_ADDR_OUTPUT_MODE: mode_sh <= reg_wdata[5:0];
        JLC_ADDR_FPM:         fpm_sh <= reg_wdata;
        JLC_ADDR_SW_SYNC:     sync_sh <= reg_wdata[0];
        default: ;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_strobes_exclusive:
    assert property (!(reg_wr && reg_rd)) else $error("both strobes high");
  a_rdata_idle_zero:
    assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data without read");
  a_unmapped_zero:
    assert property (reg_rd && !(reg_addr inside {[10'h200:10'h203]}) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
  a_enable_readback:
    assert property (reg_rd && reg_addr == JLC_ADDR_LINK_ENABLE
      |=> reg_rdata == {7'h00, $past(en_sh)}) else $error("link enable read wrong");
  a_mode_readback:
    assert property (reg_rd && reg_addr == JLC_ADDR_OUTPUT_MODE
      |=> reg_rdata == {2'h0, $past(mode_sh)}) else $error("mode read wrong");
  a_fpm_readback:
    assert property (reg_rd && reg_addr == JLC_ADDR_FPM |=> reg_rdata == $past(fpm_sh))
      else $error("frame count read wrong");
  a_sync_readback:
    assert property (reg_rd && reg_addr == JLC_ADDR_SW_SYNC
      |=> reg_rdata == {7'h00, $past(sync_sh)}) else $error("sync bit read wrong");
  a_mode_live_guard:
    assert property (reg_wr && reg_addr == JLC_ADDR_OUTPUT_MODE |-> !en_sh)
      else $error("mode written with link on");
  a_fpm_live_guard:
    assert property (reg_wr && reg_addr == JLC_ADDR_FPM |-> !en_sh)
      else $error("frame count written with link on");
  a_cfg_live_guard:
    assert property (reg_wr && reg_addr inside {[10'h204:10'h20f]} |-> !en_sh)
      else $error("config written with link on");
endmodule

// ---- tb_top.sv ----
// Purpose: drives controller software port, judges link outputs
// Assumes: 25 MHz clock, srst held 16 cycles
// Notes:   device register writes go only through the controller
`timescale 1ns/1ns
module tb_top
  import jlc_pkg::*;
;
  logic        clk, srst, cal_enable, mode_is_64b66b, sync_se_n, sync_tmstp_n, sysref;
  logic        fpm_legal, sw_wr, sw_rd, link_block_reset, serializer_power_down;
  logic        link_clock_enable, sync_request, multiframe_boundary, cal_clear_allowed;
  logic [1:0]  sync_sel;
  logic [7:0]  mode_e, mode_f;
  logic [5:0]  output_mode_select;
  logic [3:0]  sw_addr;
  logic [15:0] sw_wdata, sw_rdata, st, effective_k, multiframe_count;
  int          err_total, num_checks;
  jlc_link_if link_if (.clk(clk));
  jlc_device jlc_device_i (.clk(clk), .srst(srst), .bus(link_if), .cal_enable(cal_enable),
    .sync_sel(sync_sel), .mode_is_64b66b(mode_is_64b66b), .mode_e(mode_e), .mode_f(mode_f),
    .sync_se_n(sync_se_n), .sync_tmstp_n(sync_tmstp_n), .sysref(sysref),
    .link_block_reset(link_block_reset), .serializer_power_down(serializer_power_down),
    .link_clock_enable(link_clock_enable), .output_mode_select(output_mode_select),
    .effective_k(effective_k), .sync_request(sync_request),
    .multiframe_count(multiframe_count), .multiframe_boundary(multiframe_boundary));
  jlc_host jlc_host_i (.clk(clk), .srst(srst), .bus(link_if), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .cal_enable(cal_enable), .fpm_legal(fpm_legal), .cal_clear_allowed(cal_clear_allowed));
  jlc_link_checker jlc_link_checker_i (.clk(clk), .srst(srst), .reg_addr(link_if.reg_addr),
    .reg_wdata(link_if.reg_wdata), .reg_wr(link_if.reg_wr), .reg_rd(link_if.reg_rd),
    .reg_rdata(link_if.reg_rdata));
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask
  task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) begin sw_addr <= a; sw_wdata <= d; sw_wr <= 1'b1; end
    @(posedge clk) sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk) begin sw_addr <= a; sw_rd <= 1'b1; end
    @(posedge clk) sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  // clears sticky status first so refused always reflects this command
  task automatic cmd(input logic [15:0] go, input logic [15:0] a, input logic [15:0] d);
    sw_write(JLC_H_STATUS, 16'h0006);
    sw_write(JLC_H_ADDR, a);
    sw_write(JLC_H_DATA, d);
    sw_write(JLC_H_GO, go);
    st = 16'h0001;
    for (int i = 0; i < 20 && st[0] !== 1'b0; i++) sw_read(JLC_H_STATUS, st);
    chk("busy", 16'h0000, {15'h0000, st[0]});
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic refused);
    cmd(16'h0001, a, d);
    chk("refused", {13'h0000, refused, 2'h0}, st & 16'h0004);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    cmd(16'h0002, a, 16'h0000);
    sw_read(JLC_H_RDATA, st);
    chk("read data", exp, st);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(16'h0200, 16'h0001);
    rd(16'h0201, 16'h0000);
    rd(16'h0202, 16'h001f);
    rd(16'h0203, 16'h0001);
    rd(16'h02ff, 16'h0000);
    chk("k", 16'h0020, effective_k);
    chk("lce", 16'h0001, {15'h0000, link_clock_enable});
  endtask
  task automatic t_config;
    wr(16'h0201, 16'h0005, 1'b1);
    wr(16'h0200, 16'h0000, 1'b0);
    chk("off", 16'h0006,
        {13'h0, link_block_reset, serializer_power_down, link_clock_enable});
    chk("cal clr", 16'h0001, {15'h0000, cal_clear_allowed});
    wr(16'h0201, 16'h0005, 1'b1);
    @(posedge clk) sysref <= 1'b1;
    repeat (4) @(posedge clk);
    sysref <= 1'b0;
    repeat (8) @(posedge clk);
    chk("count", 16'h0000, multiframe_count);
    cal_enable <= 1'b0;
    wr(16'h0201, 16'h00ff, 1'b0);
    rd(16'h0201, 16'h003f);
    chk("mode", 16'h003f, {10'h000, output_mode_select});
    wr(16'h0204, 16'h0000, 1'b0);
    wr(16'h0202, 16'h000f, 1'b0);
    chk("k", 16'h0010, effective_k);
    @(posedge clk) fpm_legal <= 1'b0;
    wr(16'h0202, 16'h0007, 1'b1);
    @(posedge clk) fpm_legal <= 1'b1;
    chk("k kept", 16'h0010, effective_k);
    @(posedge clk) begin mode_is_64b66b <= 1'b1; mode_e <= 8'h02; mode_f <= 8'h04; end
    repeat (3) @(posedge clk);
    chk("k 64b", 16'h0080, effective_k);
    mode_is_64b66b <= 1'b0;
    wr(16'h0200, 16'h0001, 1'b1);
    @(posedge clk) cal_enable <= 1'b1;
    wr(16'h0200, 16'h0001, 1'b0);
    chk("lce", 16'h0001, {15'h0000, link_clock_enable});
  endtask
  task automatic t_count;
    for (int i = 0; i < 40 && multiframe_boundary !== 1'b1; i++) @(posedge clk) #1;
    repeat (16) @(posedge clk);
    #1 chk("boundary", 16'h0001, {15'h0000, multiframe_boundary});
    wr(16'h0202, 16'h0003, 1'b1);
  endtask
  task automatic t_sync;
    for (int s = 0; s < 3; s++) begin
      @(posedge clk) begin sync_sel <= s[1:0]; sync_se_n <= 1'b0; sync_tmstp_n <= 1'b0; end
      repeat (8) @(posedge clk);
      chk("pin req", {15'h0000, s != 2}, {15'h0000, sync_request});
      @(posedge clk) begin sync_se_n <= 1'b1; sync_tmstp_n <= 1'b1; end
      wr(16'h0203, 16'h0000, 1'b0);
      chk("sw req", 16'h0001, {15'h0000, sync_request});
      wr(16'h0203, 16'h0001, 1'b0);
      chk("no req", 16'h0000, {15'h0000, sync_request});
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // run
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #(40 * 20000);
    err_total++;
    final_report();
  end
  initial begin
    {srst, cal_enable, fpm_legal, sync_se_n, sync_tmstp_n} = 5'h1f;
    {sw_wr, sw_rd, sysref, mode_is_64b66b, sync_sel} = 6'h00;
    {mode_e, mode_f, sw_addr, sw_wdata} = 36'h0_0000_0000;
    err_total = 0;
    num_checks = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_config();
    t_count();
    t_sync();
    final_report();
  end
endmodule
